// ---- design/dt_exec_pkg.sv ----
// constants, types and decode helpers for the data-transfer execution core
package dt_exec_pkg;

   // reset and addressing
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [7:0]  SHORT_PAGE = 8'hff;
   localparam logic [15:0] STEP_BYTE  = 16'h0001;
   localparam logic [15:0] STEP_WORD  = 16'h0002;
   localparam logic [15:0] WORD_BYTES = 16'h0002;
   localparam logic [2:0]  SP_IDX     = 3'h7;

   // field positions inside the first instruction word
   localparam int LB_MSB   = 15;
   localparam int LB_LSB   = 8;
   localparam int PAIR_BIT = 7;

   // leading bytes
   localparam logic [7:0] LB_RR_B    = 8'h0c;
   localparam logic [7:0] LB_RR_W    = 8'h0d;
   localparam logic [7:0] LB_IMM3    = 8'h0e;
   localparam logic [7:0] LB_PCREL   = 8'h58;
   localparam logic [7:0] LB_IND_B   = 8'h68;
   localparam logic [7:0] LB_IND_W   = 8'h69;
   localparam logic [7:0] LB_ABS16_B = 8'h6a;
   localparam logic [7:0] LB_ABS16_W = 8'h6b;
   localparam logic [7:0] LB_PP_B    = 8'h6c;
   localparam logic [7:0] LB_PP_W    = 8'h6d;
   localparam logic [7:0] LB_DISP_B  = 8'h6e;
   localparam logic [7:0] LB_DISP_W  = 8'h6f;
   localparam logic [7:0] LB_IMM16   = 8'h79;

   // leading nibbles of the forms that carry a register in bits 11:8
   localparam logic [3:0] NIB_ABS8_LD = 4'h2;
   localparam logic [3:0] NIB_ABS8_ST = 4'h3;
   localparam logic [3:0] NIB_IMM8    = 4'hf;

   typedef enum logic [3:0] {
      OP_RR, OP_IMM3, OP_IMM8, OP_IMM16, OP_IND, OP_DISP, OP_PP, OP_ABS8, OP_ABS16, OP_PCREL, OP_BAD
   } op_t;

   typedef enum logic [3:0] {
      ST_BOOT, ST_F1, ST_F1W, ST_F2, ST_F2W, ST_X1, ST_X2, ST_D, ST_DW
   } seq_t;

   // instruction class from the leading byte; bit 7 set makes the imm3, pc-relative and imm16 codes invalid
   function automatic op_t decode_op(input logic [15:0] w);
      logic [7:0] lb;
      lb = w[LB_MSB:LB_LSB];
      decode_op = OP_BAD;
      case (lb)
         LB_RR_B, LB_RR_W:         decode_op = OP_RR;
         LB_IMM3:                  decode_op = w[PAIR_BIT] ? OP_BAD : OP_IMM3;
         LB_PCREL:                 decode_op = w[PAIR_BIT] ? OP_BAD : OP_PCREL;
         LB_IMM16:                 decode_op = w[PAIR_BIT] ? OP_BAD : OP_IMM16;
         LB_IND_B, LB_IND_W:       decode_op = OP_IND;
         LB_ABS16_B, LB_ABS16_W:   decode_op = OP_ABS16;
         LB_PP_B, LB_PP_W:         decode_op = OP_PP;
         LB_DISP_B, LB_DISP_W:     decode_op = OP_DISP;
         default:
         begin
            if (lb[7:4] == NIB_ABS8_LD || lb[7:4] == NIB_ABS8_ST)
               decode_op = OP_ABS8;
            else if (lb[7:4] == NIB_IMM8)
               decode_op = OP_IMM8;
         end
      endcase
   endfunction

   // byte-size forms; the 6x group is byte when the leading byte is even
   function automatic logic is_byte_op(input logic [15:0] w);
      logic [7:0] lb;
      lb = w[LB_MSB:LB_LSB];
      is_byte_op = (lb[7:4] == NIB_ABS8_LD) || (lb[7:4] == NIB_ABS8_ST) || (lb[7:4] == NIB_IMM8) ||
                   (lb == LB_RR_B) || (lb == LB_IMM3) || (lb == LB_PCREL) || ((lb[7:4] == 4'h6) && !lb[0]);
   endfunction

   // memory-writing forms
   function automatic logic is_store_op(input logic [15:0] w);
      op_t o;
      o = decode_op(w);
      is_store_op = (o == OP_ABS8) ? (w[LB_MSB:12] == NIB_ABS8_ST) :
                    ((o == OP_IND) || (o == OP_DISP) || (o == OP_PP) || (o == OP_ABS16)) && w[PAIR_BIT];
   endfunction

   // one half of a word register
   function automatic logic [7:0] byte_of(input logic [15:0] w, input logic low);
      byte_of = low ? w[7:0] : w[15:8];
   endfunction

endpackage

// ---- design/gp_reg_file.sv ----
// eight 16-bit general registers with byte-half write
`timescale 1ns/1ps
module gp_reg_file
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_idx,
   input  wire logic        wr_byte,
   input  wire logic        wr_low,
   input  wire logic [15:0] wr_data,
   input  wire logic [2:0]  rd_a_idx,
   input  wire logic [2:0]  rd_b_idx,
   output logic      [15:0] rd_a,
   output logic      [15:0] rd_b
);

   typedef struct packed {
      logic [7:0][15:0] regs;
   } rf_state_t;

   rf_state_t rf_r;
   rf_state_t rf_nxt;

   // reads are combinational so a single cycle can read, compute and write
   assign rd_a = rf_r.regs[rd_a_idx];
   assign rd_b = rf_r.regs[rd_b_idx];

   // byte writes touch only the selected half
   always_comb
   begin
      rf_nxt = rf_r;
      if (wr_en)
      begin
         if (!wr_byte)
            rf_nxt.regs[wr_idx] = wr_data;
         else if (wr_low)
            rf_nxt.regs[wr_idx][7:0] = wr_data[7:0];
         else
            rf_nxt.regs[wr_idx][15:8] = wr_data[7:0];
      end
   end

   // register bank
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rf_r <= '0;
      else if (ce)
         rf_r <= rf_nxt;
   end

endmodule // gp_reg_file

// ---- design/cpu_data_transfer_exec.sv ----
// fetch, decode and execute of the data-transfer instruction group
// How it works
// - leading byte bits 15:8 picks instruction
// - bit 7 splits pairs sharing leading byte
// - register operands are 8 or 16 bits
// - immediates decode as 3, 8 or 16 bits
// - 16-bit displacement added to base, 8-bit to pc
// - absolute address in 8-bit and 16-bit forms
// - moves set n z, clear v, keep c
// - unaffected flags keep their previous value
// - no flag left unfixed by these moves
// - byte load base+d16: 4 bytes, 6 states
// - byte store base+d16: 4 bytes, 6 states
// - word load base+d16: 4 bytes, 6 states
// - word store base+d16: 4 bytes, 6 states
`timescale 1ns/1ps
module cpu_data_transfer_exec
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        flags_load,
   input  wire logic [3:0]  flags_in,
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_byte,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   output logic             flag_n,
   output logic             flag_z,
   output logic             flag_v,
   output logic             flag_c,
   output logic      [15:0] program_counter,
   output logic             instr_done,
   output logic             unknown_op
);

   typedef struct packed {
      dt_exec_pkg::seq_t st;
      logic [15:0]       pc;
      logic [15:0]       ir;
      logic [15:0]       ext;
      logic [15:0]       ea;
      logic              n;
      logic              z;
      logic              v;
      logic              c;
      logic              mem_req;
      logic              mem_we;
      logic              mem_byte;
      logic [15:0]       mem_addr;
      logic [15:0]       mem_wdata;
      logic              done;
      logic              unknown;
   } core_state_t;

   core_state_t       s_r;
   core_state_t       s_nxt;
   logic [15:0]       cur;
   dt_exec_pkg::op_t  op;
   logic              is_byte;
   logic              is_store;
   logic [2:0]        ptr_idx;
   logic [2:0]        dat_idx;
   logic              dat_low;
   logic [15:0]       qa;
   logic [15:0]       qb;
   logic [15:0]       step;
   logic [15:0]       ptr_inc;
   logic [15:0]       ptr_dec;
   logic [15:0]       pc_plus2;
   logic              wr_en;
   logic [2:0]        wr_idx;
   logic              wr_byte;
   logic              wr_low;
   logic [15:0]       wr_data;
   logic [15:0]       xfer_val;
   logic              set_flags;
   logic              go_fetch;
   logic              go_access;
   logic [15:0]       acc_addr;

   // the word under decode is on the bus in the first wait state, latched after
   assign cur      = (s_r.st == dt_exec_pkg::ST_F1W) ? mem_rdata : s_r.ir;
   assign op       = dt_exec_pkg::decode_op(cur);
   assign is_byte  = dt_exec_pkg::is_byte_op(cur);
   assign is_store = dt_exec_pkg::is_store_op(cur);
   assign ptr_idx  = cur[6:4];
   assign dat_idx  = (op == dt_exec_pkg::OP_ABS8 || op == dt_exec_pkg::OP_IMM8) ? cur[10:8] : cur[2:0];
   assign dat_low  = (op == dt_exec_pkg::OP_ABS8 || op == dt_exec_pkg::OP_IMM8) ? cur[11] : cur[3];
   assign step     = is_byte ? dt_exec_pkg::STEP_BYTE : dt_exec_pkg::STEP_WORD;
   assign ptr_inc  = qa + step;
   assign ptr_dec  = qa - step;
   assign pc_plus2 = s_r.pc + dt_exec_pkg::WORD_BYTES;

   // single write port; the extra states of the auto-index forms give it a second slot
   gp_reg_file u_regs
   (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .wr_en    (wr_en),
      .wr_idx   (wr_idx),
      .wr_byte  (wr_byte),
      .wr_low   (wr_low),
      .wr_data  (wr_data),
      .rd_a_idx (ptr_idx),
      .rd_b_idx (dat_idx),
      .rd_a     (qa),
      .rd_b     (qb)
   );

   // sequencer: every bus access is one request state and one data state
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.done    = 1'b0;
      s_nxt.unknown = 1'b0;
      wr_en         = 1'b0;
      wr_idx        = dat_idx;
      wr_byte       = is_byte;
      wr_low        = dat_low;
      wr_data       = 16'h0000;
      xfer_val      = 16'h0000;
      set_flags     = 1'b0;
      go_fetch      = 1'b0;
      go_access     = 1'b0;
      acc_addr      = qa;
      if (flags_load)
         {s_nxt.n, s_nxt.z, s_nxt.v, s_nxt.c} = flags_in;
      case (s_r.st)
         dt_exec_pkg::ST_BOOT:
            go_fetch = 1'b1;
         dt_exec_pkg::ST_F1, dt_exec_pkg::ST_F2, dt_exec_pkg::ST_D:
         begin
            s_nxt.mem_req = 1'b0;
            s_nxt.st      = (s_r.st == dt_exec_pkg::ST_F1) ? dt_exec_pkg::ST_F1W :
                            (s_r.st == dt_exec_pkg::ST_F2) ? dt_exec_pkg::ST_F2W : dt_exec_pkg::ST_DW;
         end
         dt_exec_pkg::ST_F1W:
         begin
            s_nxt.ir = mem_rdata;
            s_nxt.pc = pc_plus2;
            case (op)
               dt_exec_pkg::OP_RR:
               begin
                  xfer_val  = is_byte ? {8'h00, dt_exec_pkg::byte_of(qa, cur[7])} : qa;
                  wr_en     = 1'b1;
                  set_flags = 1'b1;
                  go_fetch  = 1'b1;
               end
               dt_exec_pkg::OP_IMM3, dt_exec_pkg::OP_IMM8:
               begin
                  xfer_val  = (op == dt_exec_pkg::OP_IMM3) ? {13'h0000, cur[6:4]} : {8'h00, cur[7:0]};
                  wr_en     = 1'b1;
                  set_flags = 1'b1;
                  go_fetch  = 1'b1;
               end
               dt_exec_pkg::OP_IMM16, dt_exec_pkg::OP_DISP, dt_exec_pkg::OP_ABS16, dt_exec_pkg::OP_PCREL:
               begin
                  // second instruction word follows at once
                  s_nxt.mem_req  = 1'b1;
                  s_nxt.mem_we   = 1'b0;
                  s_nxt.mem_byte = 1'b0;
                  s_nxt.mem_addr = pc_plus2;
                  s_nxt.st       = dt_exec_pkg::ST_F2;
               end
               dt_exec_pkg::OP_IND:
                  go_access = 1'b1;
               dt_exec_pkg::OP_ABS8:
               begin
                  acc_addr  = {dt_exec_pkg::SHORT_PAGE, cur[7:0]};
                  go_access = 1'b1;
               end
               dt_exec_pkg::OP_PP:
               begin
                  if (is_store)
                     s_nxt.st = dt_exec_pkg::ST_X1;
                  else
                     go_access = 1'b1;
               end
               default:
               begin
                  // unknown codes retire as a two-state no-op, nothing written
                  s_nxt.unknown = 1'b1;
                  go_fetch      = 1'b1;
               end
            endcase
         end
         dt_exec_pkg::ST_F2W:
         begin
            s_nxt.ext = mem_rdata;
            s_nxt.pc  = pc_plus2;
            case (op)
               dt_exec_pkg::OP_IMM16:
               begin
                  xfer_val  = mem_rdata;
                  wr_en     = 1'b1;
                  set_flags = 1'b1;
                  go_fetch  = 1'b1;
               end
               dt_exec_pkg::OP_DISP:
               begin
                  acc_addr  = qa + mem_rdata;
                  go_access = 1'b1;
               end
               dt_exec_pkg::OP_ABS16:
               begin
                  acc_addr  = mem_rdata;
                  go_access = 1'b1;
               end
               default:
               begin
                  // pc-relative from the end of the instruction
                  acc_addr  = pc_plus2 + {{8{mem_rdata[7]}}, mem_rdata[7:0]};
                  go_access = 1'b1;
               end
            endcase
         end
         dt_exec_pkg::ST_X1:
         begin
            wr_en    = 1'b1;
            wr_idx   = ptr_idx;
            wr_byte  = 1'b0;
            wr_data  = is_store ? ptr_dec : ptr_inc;
            s_nxt.st = dt_exec_pkg::ST_X2;
         end
         dt_exec_pkg::ST_X2:
         begin
            if (is_store)
               go_access = 1'b1;
            else
               go_fetch = 1'b1;
         end
         dt_exec_pkg::ST_DW:
         begin
            if (is_store)
               xfer_val = is_byte ? {8'h00, s_r.mem_wdata[7:0]} : s_r.mem_wdata;
            else
            begin
               xfer_val = is_byte ? {8'h00, dt_exec_pkg::byte_of(mem_rdata, s_r.ea[0])} : mem_rdata;
               wr_en    = 1'b1;
            end
            set_flags = 1'b1;
            if (op == dt_exec_pkg::OP_PP && !is_store)
               s_nxt.st = dt_exec_pkg::ST_X1;
            else
               go_fetch = 1'b1;
         end
         default:
            s_nxt.st = dt_exec_pkg::ST_BOOT;
      endcase
      if (wr_en && s_r.st != dt_exec_pkg::ST_X1)
         wr_data = xfer_val;
      // instruction result wins over a same-cycle software flag load
      if (set_flags)
      begin
         s_nxt.n = is_byte ? xfer_val[7] : xfer_val[15];
         s_nxt.z = is_byte ? (xfer_val[7:0] == 8'h00) : (xfer_val == 16'h0000);
         s_nxt.v = 1'b0;
      end
      // carry is not written by a move, so it keeps its value unless a flag load sets it
      if (go_access)
      begin
         s_nxt.mem_req   = 1'b1;
         s_nxt.mem_we    = is_store;
         s_nxt.mem_byte  = is_byte;
         s_nxt.mem_addr  = acc_addr;
         s_nxt.ea        = acc_addr;
         s_nxt.mem_wdata = is_byte ? {2{dt_exec_pkg::byte_of(qb, dat_low)}} : qb;
         s_nxt.st        = dt_exec_pkg::ST_D;
      end
      if (go_fetch)
      begin
         s_nxt.mem_req  = 1'b1;
         s_nxt.mem_we   = 1'b0;
         s_nxt.mem_byte = 1'b0;
         s_nxt.mem_addr = s_nxt.pc;
         s_nxt.done     = (s_r.st != dt_exec_pkg::ST_BOOT);
         s_nxt.st       = dt_exec_pkg::ST_F1;
      end
   end

   // state register; ce low freezes everything
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r    <= '0;
         s_r.st <= dt_exec_pkg::ST_BOOT;
         s_r.pc <= dt_exec_pkg::PC_RESET;
      end
      else if (ce)
         s_r <= s_nxt;
   end

   // outputs straight from the state flops
   assign mem_req         = s_r.mem_req;
   assign mem_we          = s_r.mem_we;
   assign mem_byte        = s_r.mem_byte;
   assign mem_addr        = s_r.mem_addr;
   assign mem_wdata       = s_r.mem_wdata;
   assign flag_n          = s_r.n;
   assign flag_z          = s_r.z;
   assign flag_v          = s_r.v;
   assign flag_c          = s_r.c;
   assign program_counter = s_r.pc;
   assign instr_done      = s_r.done;
   assign unknown_op      = s_r.unknown;

   // checks on the sequencer; cycle counts only hold while ce stays high
   property p_lead_byte;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && mem_rdata[15:8] == dt_exec_pkg::LB_IND_W) |=> (s_r.st == dt_exec_pkg::ST_D);
   endproperty
   a_lead_byte: assert property (p_lead_byte) else $error("indirect word code did not start an access");

   property p_pair_bit;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && mem_rdata[15:8] == dt_exec_pkg::LB_IND_B) |=>
         (mem_req && mem_byte && mem_we == $past(mem_rdata[7]));
   endproperty
   a_pair_bit: assert property (p_pair_bit) else $error("bit 7 did not choose load or store");

   property p_imm3;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && op == dt_exec_pkg::OP_IMM3) |->
         (wr_en && wr_byte && wr_data[7:0] == {5'h00, mem_rdata[6:4]});
   endproperty
   a_imm3: assert property (p_imm3) else $error("3-bit immediate decoded wrongly");

   property p_disp_addr;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F2W && op == dt_exec_pkg::OP_DISP) |=> (mem_addr == $past(qa + mem_rdata));
   endproperty
   a_disp_addr: assert property (p_disp_addr) else $error("displacement address wrong");

   property p_abs8;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && op == dt_exec_pkg::OP_ABS8) |=>
         (mem_addr == {dt_exec_pkg::SHORT_PAGE, $past(mem_rdata[7:0])});
   endproperty
   a_abs8: assert property (p_abs8) else $error("short absolute address wrong");

   property p_flags;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      // a same-cycle flag load still owns the carry
      (set_flags && !is_byte) |=>
         (!flag_v && flag_c == ($past(flags_load) ? $past(flags_in[0]) : $past(s_r.c)) &&
          flag_n == $past(xfer_val[15]) && flag_z == ($past(xfer_val) == 16'h0000));
   endproperty
   a_flags: assert property (p_flags) else $error("move flag update wrong");

   property p_disp_len;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && op == dt_exec_pkg::OP_DISP) |=>
         (s_r.st == dt_exec_pkg::ST_F2) ##1 (s_r.st == dt_exec_pkg::ST_F2W) ##1 (s_r.st == dt_exec_pkg::ST_D)
         ##1 (s_r.st == dt_exec_pkg::ST_DW) ##1 (s_r.st == dt_exec_pkg::ST_F1 && instr_done);
   endproperty
   a_disp_len: assert property (p_disp_len) else $error("displacement move not six states");

   property p_predec;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_X1 && is_store) |-> ##2 (mem_addr == $past(ptr_dec, 2) && mem_we);
   endproperty
   a_predec: assert property (p_predec) else $error("pre-decrement store address wrong");

   property p_push_len;
      @(posedge core_clk) disable iff (!rst_b || !ce)
      (s_r.st == dt_exec_pkg::ST_F1W && op == dt_exec_pkg::OP_PP) |-> ##5 (s_r.st == dt_exec_pkg::ST_F1 && instr_done);
   endproperty
   a_push_len: assert property (p_push_len) else $error("auto-index move not six states");

   c_push: cover property (@(posedge core_clk) s_r.st == dt_exec_pkg::ST_X1 && is_store && ptr_idx == dt_exec_pkg::SP_IDX);
   c_pop: cover property (@(posedge core_clk) s_r.st == dt_exec_pkg::ST_X1 && !is_store && ptr_idx == dt_exec_pkg::SP_IDX);
   c_disp_store: cover property (@(posedge core_clk) s_r.st == dt_exec_pkg::ST_DW && op == dt_exec_pkg::OP_DISP && is_store);
   c_unknown: cover property (@(posedge core_clk) unknown_op);

endmodule // cpu_data_transfer_exec

// ---- sim/mem_model.sv ----
// registered single-port memory answering the core's operand and fetch accesses
`timescale 1ns/1ps
module mem_model
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic        mem_byte,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata
);
   logic [15:0] mem [logic [15:0]];
   logic [32:0] wlog [$];
   logic [15:0] a;
   logic [15:0] w;

   // bench preload of program words
   task automatic put(input logic [15:0] addr, input logic [15:0] data);
      mem[addr] = data;
   endtask

   // read data stands one cycle only, then toggles so stale data never looks valid
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         mem_rdata <= 16'h5a5a;
      else
      begin
         a = {mem_addr[15:1], 1'b0};
         w = mem.exists(a) ? mem[a] : 16'h0000;
         if (mem_req && !mem_we)
            mem_rdata <= w;
         else
         begin
            mem_rdata <= ~mem_rdata;
            if (mem_req)
            begin
               // big-endian lanes: even byte is the upper half
               if (!mem_byte)
                  w = mem_wdata;
               else if (mem_addr[0])
                  w[7:0] = mem_wdata[7:0];
               else
                  w[15:8] = mem_wdata[15:8];
               mem[a] = w;
               wlog.push_back({mem_byte, mem_addr, mem_wdata});
            end
         end
      end
   end
endmodule // mem_model

// ---- sim/cpu_data_transfer_exec_tb_top.sv ----
// self-checking bench for the data-transfer execution core
`timescale 1ns/1ps
module cpu_data_transfer_exec_tb_top;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic        flags_load = 1'b0;
   logic [3:0]  flags_in = 4'h0;
   logic [15:0] mem_rdata;
   logic        mem_req, mem_we, mem_byte, flag_n, flag_z, flag_v, flag_c, instr_done, unknown_op;
   logic [15:0] mem_addr, mem_wdata, program_counter;
   int          mismatches = 0;
   int          tests_run = 0;
   int          seed = 60490;
   int          k = 0;
   logic [31:0] cnt = 32'h0;
   logic [15:0] r1;
   logic [15:0] prog [18];
   int          st [14] = '{4, 6, 6, 6, 6, 6, 2, 2, 2, 4, 4, 4, 4, 2};
   logic [15:0] nx [14] = '{16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
                            16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024};
   logic        en [14];
   logic        ez [14];
   logic [19:0] frz;
   logic [32:0] ew [$];

   always #20 core_clk = ~core_clk;

   cpu_data_transfer_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .mem_rdata(mem_rdata),
      .flags_load(flags_load), .flags_in(flags_in), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v),
      .flag_c(flag_c), .program_counter(program_counter), .instr_done(instr_done), .unknown_op(unknown_op));

   mem_model u_mem (.core_clk(core_clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
      .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // per instruction: state count, next fetch address, flags and undecodable pulse
   always @(negedge core_clk)
   begin
      if (rst_b && instr_done && k < 14)
      begin
         chk(cnt, st[k]);
         chk({16'h0, mem_addr}, {16'h0, nx[k]});
         chk({16'h0, program_counter}, {16'h0, nx[k]});
         chk({flag_n, flag_z, flag_v, flag_c}, {en[k], ez[k], 2'b01});
         chk(unknown_op, k == 8);
         k++;
         cnt = 32'h1;
      end
      else if (rst_b && (mem_req || cnt != 0))
         cnt++;
   end

   initial
   begin
      r1 = $random(seed);
      // imm16, word store d16, byte load d16, byte store d16, push, pop, imm8, imm3, undecodable,
      // word load @r0, short store r4 high, short load r4 low, byte store @r4, byte reg move r5h to r6l
      prog = '{16'h7901, r1, 16'h6f81, 16'h0100, 16'h6e0a, 16'h0101, 16'h6e8a, 16'h0200,
               16'h6df1, 16'h6d73, 16'hf480, 16'h0e05, 16'h0e80, 16'h6906, 16'h3410, 16'h2c10,
               16'h68cc, 16'h0c5e};
      for (int i = 0; i < 18; i++)
         u_mem.put(16'(2 * i), prog[i]);
      for (int i = 0; i < 6; i++)
      begin
         en[i] = (i == 2 || i == 3) ? r1[7] : r1[15];
         ez[i] = (i == 2 || i == 3) ? (r1[7:0] == 8'h00) : (r1 == 16'h0000);
      end
      // fixed operands: 0x80 gives n, zero gives z
      for (int i = 6; i < 14; i++)
      begin
         en[i] = (i == 6 || (i >= 10 && i <= 12));
         ez[i] = (i == 7 || i == 8 || i == 13);
      end
      ew.push_back({1'b0, 16'h0100, r1});
      ew.push_back({1'b1, 16'h0200, r1[7:0], r1[7:0]});
      ew.push_back({1'b0, 16'hfffe, r1});
      ew.push_back({1'b1, 16'hff10, 16'h8080});
      ew.push_back({1'b1, 16'h8080, 16'h8080});
      repeat (2) @(negedge core_clk);
      rst_b = 1'b1;
      // preset v and c: moves must clear v and leave c alone
      flags_load = 1'b1;
      flags_in = 4'h3;
      @(negedge core_clk);
      flags_load = 1'b0;
      for (int t = 0; t < 400 && k < 14; t++)
         @(negedge core_clk);
      // ce low must freeze flags and fetch address while the core idles on no-op words
      ce = 1'b0;
      frz = {flag_n, flag_z, flag_v, flag_c, program_counter};
      repeat (3) @(negedge core_clk);
      chk({flag_n, flag_z, flag_v, flag_c, program_counter}, frz);
      ce = 1'b1;
      chk(k, 14);
      chk(u_mem.wlog.size(), 5);
      for (int i = 0; i < 5 && i < u_mem.wlog.size(); i++)
         chk(u_mem.wlog[i], ew[i]);
      wrap_up();
   end
endmodule // cpu_data_transfer_exec_tb_top
